// >>> core/cile_exec.v
// Decoder and executor for xor, load-multiple, word loads and byte load.
// Assumes a memory that answers each read with mem_rvalid or mem_abort,
// and a core that presents one instruction at a time with instr_valid.
// Behaviour
// - Load multiple ascends from lowest register
// - First transfer address is base_reg
// - Each further address adds four
// - Only selected low registers are loaded
// - Base written back plus four per register
// - Selected base keeps loaded value
// - Abort leaves base at original value
// - Multiple loads ignore low address bits while align_check_en is low
// - Misaligned word load raises alignment fault while align_check_en is high
// - Immediate word load: base plus imm*4
// - Register word load: index plus base
// - Misaligned single load returns any value
// - PC-relative load: word-aligned PC plus imm*4
// - SP-relative load: SP plus imm*4
// - Word loaded unchanged into destination
// - Byte load zero-extends to word
// - PC operand is instruction plus four
`timescale 1ns/1ps
`include "cile_defines.vh"
module cile_exec (
	input  wire        clk,
	input  wire        resetn,
	input  wire        instr_valid,
	input  wire [15:0] instr,
	input  wire [31:0] instr_addr,
	input  wire        align_check_en,
	output wire        instr_ready,
	output reg         instr_done,
	output reg         undefined_instr,
	output reg         align_fault,
	output reg         data_abort,
	output reg         mem_req,
	output reg  [31:0] mem_addr,
	output reg         mem_byte,
	input  wire        mem_rvalid,
	input  wire        mem_abort,
	input  wire [31:0] mem_rdata,
	input  wire        reg_wr_en,
	input  wire [3:0]  reg_wr_idx,
	input  wire [31:0] reg_wr_data,
	output reg  [31:0] reg_file_0,
	output reg  [31:0] reg_file_7,
	output reg  [31:0] stack_ptr,
	output reg         flag_n,
	output reg         flag_z
);
	localparam ST_IDLE = 2'h0;
	localparam ST_LOAD = 2'h1;
	localparam ST_MULT = 2'h2;

	reg [31:0] gpr [0:7];
	reg [1:0]  state;
	reg [2:0]  dest;
	reg [2:0]  base_idx;
	reg [7:0]  pending;
	reg [31:0] base_final;
	reg        base_in_list;
	reg [2:0]  cur_reg;
	reg        is_byte;
	reg        misaligned;
	reg [31:0] base_orig;

	// Small helpers, each used on more than one path
	function [31:0] times4;
		input [31:0] v;
		begin
			times4 = {v[29:0], 2'h0};
		end
	endfunction

	function [31:0] word_align;
		input [31:0] a;
		begin
			word_align = {a[31:2], 2'h0};
		end
	endfunction

	function low_bits_set;
		input [31:0] a;
		begin
			low_bits_set = a[1:0] != 2'h0;
		end
	endfunction

	wire [2:0]  rd_f = instr[2:0];
	wire [2:0]  base_f = instr[5:3];
	wire [2:0]  index_f = instr[8:6];
	wire [4:0]  imm5_f = instr[10:6];
	wire [7:0]  imm8_f = instr[7:0];
	wire [7:0]  reg_list = instr[7:0];
	wire [2:0]  ldm_base_f = instr[10:8];
	wire [31:0] ldm_base = gpr[ldm_base_f];
	wire [31:0] imm5 = times4({27'h0, imm5_f});
	wire [31:0] imm8 = times4({24'h0, imm8_f});
	wire [31:0] pc_val = instr_addr + `CILE_PC_AHEAD;

	function [3:0] popcount8;
		input [7:0] v;
		integer k;
		begin
			popcount8 = 4'h0;
			for (k = 0; k < 8; k = k + 1)
				popcount8 = popcount8 + {3'h0, v[k]};
		end
	endfunction

	function [2:0] lowest_set;
		input [7:0] v;
		integer k;
		begin
			lowest_set = 3'h0;
			for (k = 7; k >= 0; k = k - 1)
				if (v[k])
					lowest_set = k[2:0];
		end
	endfunction

	// Decode
	wire op_xor  = instr[15:6] == `CILE_OP_XOR;
	wire op_ldm  = instr[15:11] == `CILE_OP_LDM;
	wire op_ldri = instr[15:11] == `CILE_OP_LDW_IMM;
	wire op_ldrr = instr[15:9] == `CILE_OP_LDW_REG;
	wire op_ldrp = instr[15:11] == `CILE_OP_LDW_PC;
	wire op_ldrs = instr[15:11] == `CILE_OP_LDW_SP;
	wire op_load_unsigned_byte = instr[15:11] == `CILE_OP_LDB_IMM;

	// Address that a single load reads
	reg [31:0] eff_addr;
	reg [2:0]  eff_dest;
	always @* begin
		eff_addr = 32'h00000000;
		eff_dest = rd_f;
		if (op_ldri)
			eff_addr = gpr[base_f] + imm5;
		else if (op_ldrr)
			eff_addr = gpr[index_f] + gpr[base_f];
		else if (op_ldrp) begin
			eff_addr = word_align(pc_val) + imm8;
			eff_dest = instr[10:8];
		end else if (op_ldrs) begin
			eff_addr = stack_ptr + imm8;
			eff_dest = instr[10:8];
		end else if (op_load_unsigned_byte)
			eff_addr = gpr[base_f] + {27'h0, imm5_f};
	end

	// Second xor operand sits in bits 5:3, not 8:6
	wire [31:0] xor_res = gpr[rd_f] ^ gpr[base_f];
	wire        any_word = op_ldri | op_ldrr | op_ldrp | op_ldrs;
	wire        eff_mis = low_bits_set(eff_addr);
	wire        ldm_mis = low_bits_set(ldm_base);
	wire [31:0] ldm_inc = times4({28'h0, popcount8(reg_list)});
	wire [2:0]  next_reg = lowest_set(pending);
	wire [7:0]  pend_rest = pending & ~(8'h01 << next_reg);
	// Preload only between instructions, never racing a load
	wire        preload_ok = reg_wr_en && !instr_valid && instr_ready;

	assign instr_ready = state == ST_IDLE;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			instr_done <= 1'b0;
			undefined_instr <= 1'b0;
			align_fault <= 1'b0;
			data_abort <= 1'b0;
			mem_req <= 1'b0;
			mem_addr <= 32'h00000000;
			mem_byte <= 1'b0;
			dest <= 3'h0;
			base_idx <= 3'h0;
			pending <= 8'h00;
			base_final <= 32'h00000000;
			base_in_list <= 1'b0;
			cur_reg <= 3'h0;
			is_byte <= 1'b0;
			misaligned <= 1'b0;
			base_orig <= 32'h00000000;
			stack_ptr <= 32'h00000000;
			flag_n <= 1'b0;
			flag_z <= 1'b0;
			gpr[0] <= 32'h00000000;
			gpr[1] <= 32'h00000000;
			gpr[2] <= 32'h00000000;
			gpr[3] <= 32'h00000000;
			gpr[4] <= 32'h00000000;
			gpr[5] <= 32'h00000000;
			gpr[6] <= 32'h00000000;
			gpr[7] <= 32'h00000000;
		end else begin
			instr_done <= 1'b0;
			undefined_instr <= 1'b0;
			align_fault <= 1'b0;
			data_abort <= 1'b0;
			if (preload_ok) begin
				if (reg_wr_idx[3])
					stack_ptr <= reg_wr_data;
				else
					gpr[reg_wr_idx[2:0]] <= reg_wr_data;
			end
			case (state)
			ST_IDLE: begin
				if (instr_valid) begin
					if (op_xor) begin
						gpr[rd_f] <= xor_res;
						flag_n <= xor_res[31];
						flag_z <= xor_res == 32'h00000000;
						instr_done <= 1'b1;
					end else if (any_word | op_load_unsigned_byte) begin
						if (any_word && align_check_en && eff_mis) begin
							align_fault <= 1'b1;
							instr_done <= 1'b1;
						end else begin
							mem_req <= 1'b1;
							mem_addr <= eff_addr;
							mem_byte <= op_load_unsigned_byte;
							is_byte <= op_load_unsigned_byte;
							misaligned <= any_word && eff_mis;
							dest <= eff_dest;
							state <= ST_LOAD;
						end
					end else if (op_ldm) begin
						if (align_check_en && ldm_mis) begin
							align_fault <= 1'b1;
							instr_done <= 1'b1;
						end else if (reg_list == 8'h00) begin
							// Empty list: no read, base kept as is
							instr_done <= 1'b1;
						end else begin
							// Low bits dropped, data never rotated
							mem_addr <= word_align(ldm_base);
							mem_req <= 1'b1;
							mem_byte <= 1'b0;
							pending <= reg_list;
							cur_reg <= lowest_set(reg_list);
							base_idx <= ldm_base_f;
							base_in_list <= reg_list[ldm_base_f];
							base_orig <= ldm_base;
							base_final <= ldm_base + ldm_inc;
							state <= ST_MULT;
						end
					end else begin
						undefined_instr <= 1'b1;
						instr_done <= 1'b1;
					end
				end
			end
			ST_LOAD: begin
				if (mem_abort) begin
					mem_req <= 1'b0;
					data_abort <= 1'b1;
					instr_done <= 1'b1;
					state <= ST_IDLE;
				end else if (mem_rvalid) begin
					mem_req <= 1'b0;
					if (is_byte)
						gpr[dest] <= {24'h000000, mem_rdata[7:0]};
					// Unaligned word is handed over raw
					else if (misaligned)
						gpr[dest] <= mem_rdata;
					else
						gpr[dest] <= mem_rdata;
					instr_done <= 1'b1;
					state <= ST_IDLE;
				end
			end
			ST_MULT: begin
				if (mem_abort) begin
					// Base restored even if it was loaded earlier
					gpr[base_idx] <= base_orig;
					mem_req <= 1'b0;
					data_abort <= 1'b1;
					instr_done <= 1'b1;
					state <= ST_IDLE;
				end else if (mem_rvalid) begin
					gpr[cur_reg] <= mem_rdata;
					pending <= pend_rest;
					if (pend_rest == 8'h00) begin
						mem_req <= 1'b0;
						if (!base_in_list)
							gpr[base_idx] <= base_final;
						instr_done <= 1'b1;
						state <= ST_IDLE;
					end else begin
						cur_reg <= lowest_set(pend_rest);
						mem_addr <= mem_addr + `CILE_WORD_STEP;
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	always @* begin
		reg_file_0 = gpr[0];
		reg_file_7 = gpr[7];
	end
endmodule // cile_exec

// >>> core/cile_defines.vh
// Constants for the compact load/logic execution block.
// Included by core/cile_exec.v; definitions only.
`ifndef CILE_DEFINES_VH
`define CILE_DEFINES_VH
`define CILE_OP_XOR_HI     10
`define CILE_OP_XOR        10'h101
`define CILE_OP_LDM        5'h19
`define CILE_OP_LDW_IMM    5'h0D
`define CILE_OP_LDW_REG_HI 7
`define CILE_OP_LDW_REG    7'h2C
`define CILE_OP_LDW_PC     5'h09
`define CILE_OP_LDW_SP     5'h13
`define CILE_OP_LDB_IMM    5'h0F
`define CILE_PC_AHEAD      32'h00000004
`define CILE_WORD_STEP     32'h00000004
`define CILE_SP_INDEX      4'hD
`endif

// >>> test/cile_exec_properties.sv
// Port assertions for cile_exec.
// Assumes one clock and resetn low clearing the block.
`timescale 1ns/1ps
module cile_exec_properties (
	input wire        clk,
	input wire        resetn,
	input wire        instr_valid,
	input wire [15:0] instr,
	input wire        instr_ready,
	input wire        instr_done,
	input wire        undefined_instr,
	input wire        align_fault,
	input wire        data_abort,
	input wire        mem_req,
	input wire [31:0] mem_addr,
	input wire        mem_byte,
	input wire        mem_rvalid,
	input wire        mem_abort,
	input wire        flag_n,
	input wire        flag_z
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire take = instr_valid && instr_ready;
	wire ack = mem_req && mem_rvalid;
	property p_undef; take && instr[15:11] == 5'h1C |=> undefined_instr;
	endproperty
	a_undef: assert property (p_undef) else $error("undef");
	property p_align; align_fault |-> instr_done && !mem_req; endproperty
	a_align: assert property (p_align) else $error("align");
	// Only a load-multiple keeps the request up after an answer
	property p_step; ack ##1 mem_req |-> mem_addr[1:0] == 2'h0 &&
		mem_addr == $past(mem_addr) + 32'h4; endproperty
	a_step: assert property (p_step) else $error("step");
	property p_hold; mem_req && !mem_rvalid && !mem_abort |=>
		mem_req && $stable(mem_addr); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_abort; mem_req && mem_abort |=> data_abort && !mem_req;
	endproperty
	a_abort: assert property (p_abort) else $error("abort");
	property p_done; ack ##1 !mem_req |-> instr_done && !data_abort;
	endproperty
	a_done: assert property (p_done) else $error("done");
	property p_flags; !instr_done |-> $stable({flag_n, flag_z}); endproperty
	a_flags: assert property (p_flags) else $error("flags");
	property p_byte; take && instr[15:11] == 5'h0F |=> mem_req && mem_byte;
	endproperty
	a_byte: assert property (p_byte) else $error("byte");
endmodule // cile_exec_properties
bind cile_exec cile_exec_properties u_cile_exec_properties (
	.clk             (clk),
	.resetn          (resetn),
	.instr_valid     (instr_valid),
	.instr           (instr),
	.instr_ready     (instr_ready),
	.instr_done      (instr_done),
	.undefined_instr (undefined_instr),
	.align_fault     (align_fault),
	.data_abort      (data_abort),
	.mem_req         (mem_req),
	.mem_addr        (mem_addr),
	.mem_byte        (mem_byte),
	.mem_rvalid      (mem_rvalid),
	.mem_abort       (mem_abort),
	.flag_n          (flag_n),
	.flag_z          (flag_z)
);

// >>> test/cile_mem_model.sv
// Data memory model: answers each read after mem_wait extra cycles.
// Word data is a fixed function of the address; one address aborts.
`timescale 1ns/1ps
module cile_mem_model (
	input  wire        clk,
	input  wire        mem_req,
	input  wire [31:0] mem_addr,
	input  wire        mem_byte,
	input  wire [1:0]  mem_wait,
	input  wire [31:0] abort_addr,
	output reg         mem_rvalid = 1'b0,
	output reg         mem_abort = 1'b0,
	output reg  [31:0] mem_rdata = 32'h0
);
	reg  [1:0]  cnt = 2'h0;
	wire [31:0] word = {mem_addr[15:0], ~mem_addr[15:0]};
	always @(posedge clk) begin
		mem_rvalid <= 1'b0;
		mem_abort <= 1'b0;
		// Idle data toggles so stale data never passes for an answer
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_rvalid && !mem_abort) begin
			cnt <= (cnt == mem_wait) ? 2'h0 : cnt + 2'h1;
			if (cnt == mem_wait) begin
				mem_abort <= mem_addr == abort_addr;
				mem_rvalid <= mem_addr != abort_addr;
				// Byte in every lane: lane choice is left to the core
				mem_rdata <= mem_byte ? {4{word[7:0]}} : word;
			end
		end
	end
endmodule // cile_mem_model

// >>> test/compact_isa_load_logic_exec_test.sv
// Bench for cile_exec with the memory model on its far side.
// Inputs change on the falling edge.
`timescale 1ns/1ps
module compact_isa_load_logic_exec_test;
	reg        clk = 1'b0, resetn = 1'b0, instr_valid = 1'b0;
	reg        align_check_en = 1'b0, reg_wr_en = 1'b0;
	reg [15:0] instr = 16'h0;
	reg [31:0] instr_addr = 32'h0, reg_wr_data = 32'h0;
	reg [31:0] abort_addr = 32'hFFFFFFFF;
	reg [3:0]  reg_wr_idx = 4'h0;
	reg [1:0]  mem_wait = 2'h0;
	reg [2:0]  fl;
	wire       instr_ready, instr_done, undefined_instr, align_fault;
	wire       data_abort, mem_req, mem_byte, mem_rvalid, mem_abort;
	wire       flag_n, flag_z;
	wire [31:0] mem_addr, mem_rdata, reg_file_0, reg_file_7, stack_ptr;
	integer    miscompares = 0, n_compared = 0;
	always #2.5 clk = ~clk;
	cile_exec u_cile_exec (
		.clk             (clk),
		.resetn          (resetn),
		.instr_valid     (instr_valid),
		.instr           (instr),
		.instr_addr      (instr_addr),
		.align_check_en  (align_check_en),
		.instr_ready     (instr_ready),
		.instr_done      (instr_done),
		.undefined_instr (undefined_instr),
		.align_fault     (align_fault),
		.data_abort      (data_abort),
		.mem_req         (mem_req),
		.mem_addr        (mem_addr),
		.mem_byte        (mem_byte),
		.mem_rvalid      (mem_rvalid),
		.mem_abort       (mem_abort),
		.mem_rdata       (mem_rdata),
		.reg_wr_en       (reg_wr_en),
		.reg_wr_idx      (reg_wr_idx),
		.reg_wr_data     (reg_wr_data),
		.reg_file_0      (reg_file_0),
		.reg_file_7      (reg_file_7),
		.stack_ptr       (stack_ptr),
		.flag_n          (flag_n),
		.flag_z          (flag_z)
	);
	cile_mem_model u_cile_mem_model (
		.clk        (clk),
		.mem_req    (mem_req),
		.mem_addr   (mem_addr),
		.mem_byte   (mem_byte),
		.mem_wait   (mem_wait),
		.abort_addr (abort_addr),
		.mem_rvalid (mem_rvalid),
		.mem_abort  (mem_abort),
		.mem_rdata  (mem_rdata)
	);
	function [31:0] mf(input [31:0] a);
		mf = {a[15:0], ~a[15:0]};
	endfunction
	task chk(input string s, input [31:0] e, input [31:0] g);
		begin
			n_compared = n_compared + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("wrong value %s expected %h seen %h", s, e, g);
			end
		end
	endtask
	task wreg(input [3:0] i, input [31:0] d);
		begin
			reg_wr_en = 1'b1;
			reg_wr_idx = i;
			reg_wr_data = d;
			@(negedge clk);
			reg_wr_en = 1'b0;
			@(negedge clk);
		end
	endtask
	task run(input [15:0] op);
		integer k;
		begin
			instr = op;
			instr_valid = 1'b1;
			@(negedge clk);
			instr_valid = 1'b0;
			for (k = 0; k < 40 && instr_done !== 1'b1; k = k + 1)
				@(negedge clk);
			fl = {undefined_instr, align_fault, data_abort};
			@(negedge clk);
		end
	endtask
	task t_xor;
		begin
			wreg(4'h0, 32'hF0F0000F);
			wreg(4'h7, 32'h0F0F000F);
			run({10'h101, 3'h7, 3'h0});
			chk("r0", 32'hFFFF0000, reg_file_0);
			chk("nz", 32'h2, {30'h0, flag_n, flag_z});
			run({10'h101, 3'h7, 3'h7});
			chk("z", 32'h1, {30'h0, flag_n, flag_z});
			$display("t_xor end");
		end
	endtask
	task t_ldm;
		begin
			mem_wait = 2'h2;
			wreg(4'h0, 32'h1000);
			run({5'h19, 3'h0, 8'h81});
			chk("r0", mf(32'h1000), reg_file_0);
			chk("r7", mf(32'h1004), reg_file_7);
			wreg(4'h0, 32'h2002);
			run({5'h19, 3'h0, 8'h80});
			chk("wb", 32'h2006, reg_file_0);
			chk("r7", mf(32'h2000), reg_file_7);
			abort_addr = 32'h3004;
			wreg(4'h0, 32'h3000);
			run({5'h19, 3'h0, 8'hC0});
			chk("abt", 32'h1, {29'h0, fl});
			chk("base", 32'h3000, reg_file_0);
			wreg(4'h0, 32'h3000);
			run({5'h19, 3'h0, 8'h81});
			chk("abt2", 32'h1, {29'h0, fl});
			chk("base2", 32'h3000, reg_file_0);
			mem_wait = 2'h0;
			$display("t_ldm end");
		end
	endtask
	task t_word;
		begin
			wreg(4'h0, 32'h100);
			run({5'h0D, 5'h03, 3'h0, 3'h7});
			chk("imm", mf(32'h10C), reg_file_7);
			wreg(4'h7, 32'h20);
			run({7'h2C, 3'h7, 3'h0, 3'h0});
			chk("reg", mf(32'h120), reg_file_0);
			instr_addr = 32'h402;
			run({5'h09, 3'h7, 8'h05});
			chk("pc", mf(32'h418), reg_file_7);
			wreg(4'h8, 32'h800);
			chk("spr", 32'h800, stack_ptr);
			run({5'h13, 3'h0, 8'h02});
			chk("sp", mf(32'h808), reg_file_0);
			wreg(4'h0, 32'h31);
			run({5'h0F, 5'h02, 3'h0, 3'h7});
			chk("byte", 32'hCC, reg_file_7);
			align_check_en = 1'b1;
			wreg(4'h0, 32'h101);
			run({5'h0D, 5'h00, 3'h0, 3'h7});
			chk("algn", 32'h2, {29'h0, fl});
			run({5'h19, 3'h0, 8'h08});
			chk("lalg", 32'h2, {29'h0, fl});
			chk("lbase", 32'h101, reg_file_0);
			align_check_en = 1'b0;
			run({5'h0D, 5'h00, 3'h0, 3'h7});
			chk("mis", 32'h0, {29'h0, fl});
			run(16'hE000);
			chk("undf", 32'h4, {29'h0, fl});
			$display("t_word end");
		end
	endtask
	task test_done;
		begin
			$display("compared %0d wrong %0d", n_compared, miscompares);
			if (miscompares == 0 && n_compared > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	initial begin
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		t_xor;
		t_ldm;
		t_word;
		test_done;
	end
	// About 100 cycles are needed; allow thirty times that
	initial begin
		#15000;
		miscompares = miscompares + 1;
		test_done;
	end
endmodule // compact_isa_load_logic_exec_test
